// ==== fsg_pkg.sv ====
// Package for the sector write guard: sector map, modes and carriers.
// Assumes a 16-bit program address space with sectors at the top.
package fsg_pkg;

	localparam int ADDR_W = 16;
	// Sector 0 and 1 span fixed 4 Kbyte windows at the top of memory
	localparam logic [15:0] SEC0_BASE = 16'hF000;
	localparam logic [15:0] SEC1_BASE = 16'hE000;
	localparam logic [1:0] SIZE_4K = 2'h0;
	localparam logic [1:0] SIZE_8K = 2'h1;
	localparam logic [1:0] SIZE_BIG = 2'h2;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam logic [2:0] SEC_MASK_RST = 3'h0;

	typedef enum logic [1:0] {
		FSG_SEC0 = 2'b00,
		FSG_SEC1 = 2'b01,
		FSG_SEC2 = 2'b10,
		FSG_NONE = 2'b11
	} fsg_sector_e;

	typedef enum logic [1:0] {
		FSG_MODE_USER = 2'b00,
		FSG_MODE_TOOL = 2'b01,
		FSG_MODE_ICP = 2'b10,
		FSG_MODE_IAP = 2'b11
	} fsg_mode_e;

	typedef enum logic [1:0] {
		FSG_OP_NONE = 2'b00,
		FSG_OP_PROG = 2'b01,
		FSG_OP_SEC_ERASE = 2'b10,
		FSG_OP_BULK_ERASE = 2'b11
	} fsg_op_e;

	typedef struct packed {
		fsg_op_e op;
		logic [15:0] addr;
		logic [7:0] data;
	} fsg_req_s;

	typedef struct packed {
		fsg_op_e op;
		logic [15:0] addr;
		logic [7:0] data;
		logic [2:0] sec_mask;
		logic option;
	} fsg_cmd_s;

	typedef enum logic [1:0] {
		FSG_ST_IDLE = 2'b00,
		FSG_ST_WIPE = 2'b01,
		FSG_ST_WAIT = 2'b10
	} fsg_state_e;

endpackage : fsg_pkg

// ==== fsg_link_sync.sv ====
// Two-stage synchroniser bank for the in-circuit serial pins.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
module fsg_link_sync
	import fsg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// Raw pins
	input wire logic [1:0] async_i,
	// Synchronised levels
	output logic [1:0] sync_o
);

	logic [1:0] meta_r;
	logic [1:0] sync_r;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_r <= SYNC_RST;
			sync_r <= SYNC_RST;
		end else if (clk_en_i) begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;

endmodule : fsg_link_sync

// ==== fsg_guard.sv ====
// Sector write guard for the sectored program flash.
// Assumes the flash macro executes one command per cmd_valid_o pulse.
// Summary of operation
// (R1) Bulk erase, sector erase, byte program supported
// (R2) Tool and in-circuit modes: all sectors, options
// (R3) Application mode protects sector 0 always
// (R4) Sectors 0,1 are 4K; size sets count
// (R5) Sector 0 spans F000h to FFFFh
// (R6) Sector erase touches only its sector
// (R7) Protection blocks external reads and all writes
// (R8) Protection follows only the option bit
// (R9) Unprotect first wipes whole array automatically
// (R10) Voltage detector disabled while protected
// (R11) Tool must enter in-circuit mode first
// (R12) Tool drives reset during sessions
// (R13) Serial clock plus shared bidirectional data
// (R14) Attached tool takes serial pins from application
// (R15) Forbidden requests ignored, array unchanged
`timescale 1ns/1ps
module fsg_guard
	import fsg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// Mode and configuration
	input wire logic [1:0] mode_i,
	input wire logic [1:0] flash_size_i,
	input wire logic icc_mode_i,
	input wire logic tool_attached_i,
	// Option byte write and current option value
	input wire logic opt_wr_i,
	input wire logic opt_prot_i,
	input wire logic readout_protect_option_bit_i,
	// Request from programming software
	input wire logic req_valid_i,
	input wire fsg_req_s req_i,
	output logic req_ready_o,
	output logic req_denied_o,
	// Command to flash macro
	output logic cmd_valid_o,
	output fsg_cmd_s cmd_o,
	input wire logic cmd_done_i,
	// Read path gating
	input wire logic rd_ext_i,
	output logic rd_allow_o,
	// Voltage detector gating
	output logic lvd_enable_o,
	// In-circuit serial pins
	input wire logic incircuit_serial_clock_i,
	input wire logic incircuit_serial_data_i,
	output logic incircuit_serial_data_o,
	output logic incircuit_serial_data_oe_o,
	input wire logic link_data_o_i,
	input wire logic link_data_oe_i,
	output logic link_clk_rise_o,
	output logic link_data_o,
	// Application use of the same pins
	input wire logic app_data_o_i,
	input wire logic app_data_oe_i,
	output logic app_pins_avail_o,
	output logic app_clk_o,
	output logic app_data_o
);

	function automatic fsg_sector_e sector_of(input logic [15:0] a, input logic [1:0] sz);
		fsg_sector_e s;
		s = FSG_NONE;
		if (a >= SEC0_BASE)
			s = FSG_SEC0; // R5
		else if (a >= SEC1_BASE && sz != SIZE_4K)
			s = FSG_SEC1; // R4
		else if (a < SEC1_BASE && sz == SIZE_BIG)
			s = FSG_SEC2; // R4
		return s;
	endfunction : sector_of

	fsg_state_e state_r, state_nxt;
	logic prot_r;
	logic [1:0] pin_sync;
	logic clk_d_r;
	logic valid_r;
	fsg_cmd_s cmd_r;

	fsg_link_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.async_i({incircuit_serial_clock_i, incircuit_serial_data_i}),
		.sync_o(pin_sync)
	);

	// Decoding
	wire fsg_sector_e req_sec = sector_of(req_i.addr, flash_size_i);
	wire full_access = (mode_i == FSG_MODE_TOOL) || (mode_i == FSG_MODE_ICP && icc_mode_i); // R2 R11
	wire iap_access = (mode_i == FSG_MODE_IAP);
	wire sec_ok = (req_sec != FSG_NONE) && (full_access || (iap_access && req_sec != FSG_SEC0)); // R3
	wire bulk_ok = full_access; // R1
	wire op_ok = (req_i.op == FSG_OP_BULK_ERASE) ? bulk_ok :
		(req_i.op == FSG_OP_NONE) ? 1'b0 : sec_ok;
	wire idle = (state_r == FSG_ST_IDLE);
	wire take = clk_en_i && idle && req_valid_i;
	wire allowed = op_ok && !prot_r; // R7 R15
	wire unprot = opt_wr_i && full_access && prot_r && !opt_prot_i; // R9
	wire [2:0] one_sec = 3'h1 << req_sec;
	wire [2:0] all_secs = (flash_size_i == SIZE_4K) ? 3'h1 :
		(flash_size_i == SIZE_8K) ? 3'h3 : 3'h7;

	assign req_ready_o = idle && !unprot;
	assign req_denied_o = take && !unprot && !allowed; // R15
	assign rd_allow_o = !(prot_r && rd_ext_i); // R7
	assign lvd_enable_o = !prot_r; // R10
	assign cmd_valid_o = valid_r;
	assign cmd_o = cmd_r;

	// Serial link: attached tool owns the pins
	assign app_pins_avail_o = !tool_attached_i; // R14
	assign app_clk_o = tool_attached_i ? 1'b0 : pin_sync[1]; // R14
	assign app_data_o = tool_attached_i ? 1'b0 : pin_sync[0]; // R14
	assign link_data_o = pin_sync[0]; // R13
	assign link_clk_rise_o = pin_sync[1] && !clk_d_r; // R13
	assign incircuit_serial_data_o = tool_attached_i ? link_data_o_i : app_data_o_i; // R13
	assign incircuit_serial_data_oe_o = tool_attached_i ? (icc_mode_i && link_data_oe_i)
		: app_data_oe_i; // R14

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FSG_ST_IDLE: begin
				if (unprot)
					state_nxt = FSG_ST_WIPE;
				else if (req_valid_i && allowed)
					state_nxt = FSG_ST_WAIT;
			end
			FSG_ST_WIPE: begin
				if (cmd_done_i)
					state_nxt = FSG_ST_IDLE;
			end
			FSG_ST_WAIT: begin
				if (cmd_done_i)
					state_nxt = FSG_ST_IDLE;
			end
			default: state_nxt = FSG_ST_IDLE;
		endcase
	end

	// Protection reloaded from option bit in every idle cycle without an option write
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= FSG_ST_IDLE;
			prot_r <= 1'b1;
			clk_d_r <= 1'b0;
			valid_r <= 1'b0;
			cmd_r <= '0;
		end else if (clk_en_i) begin
			state_r <= state_nxt;
			clk_d_r <= pin_sync[1];
			valid_r <= 1'b0;
			if (idle && !opt_wr_i)
				prot_r <= readout_protect_option_bit_i; // R8
			if (idle && unprot) begin
				valid_r <= 1'b1; // R9
				cmd_r <= '{op: FSG_OP_BULK_ERASE, addr: ADDR_RST, data: 8'h00,
					sec_mask: all_secs, option: 1'b0};
			end else if (state_r == FSG_ST_WIPE && cmd_done_i) begin
				prot_r <= 1'b0; // R9
				valid_r <= 1'b1;
				cmd_r <= '{op: FSG_OP_PROG, addr: ADDR_RST, data: 8'h00,
					sec_mask: SEC_MASK_RST, option: 1'b1};
			end else if (take && allowed) begin
				valid_r <= 1'b1;
				cmd_r.op <= req_i.op;
				cmd_r.addr <= req_i.addr;
				cmd_r.data <= req_i.data;
				cmd_r.option <= 1'b0;
				cmd_r.sec_mask <= (req_i.op == FSG_OP_BULK_ERASE) ? all_secs : one_sec; // R6
			end
		end
	end

endmodule : fsg_guard

// ==== fsg_guard_chk.sv ====
// Port-level checker for the sector write guard.
// Assumes the fsg_guard port list; bound to every instance.
`timescale 1ns/1ps
module fsg_guard_chk
	import fsg_pkg::*;
(
	// Clock, mode and option
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic [1:0] mode_i,
	input wire logic [1:0] flash_size_i,
	input wire logic icc_mode_i,
	input wire logic tool_attached_i,
	input wire logic opt_wr_i,
	input wire logic opt_prot_i,
	// Requests, commands and gating
	input wire logic req_valid_i,
	input wire fsg_req_s req_i,
	input wire logic req_ready_o,
	input wire logic req_denied_o,
	input wire logic cmd_valid_o,
	input wire fsg_cmd_s cmd_o,
	input wire logic rd_ext_i,
	input wire logic rd_allow_o,
	input wire logic lvd_enable_o,
	input wire logic app_pins_avail_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	wire take = clk_en_i && req_ready_o && req_valid_i;
	wire sec0 = req_i.addr >= SEC0_BASE;
	chk_iap_sec0: assert property (
		take && mode_i == FSG_MODE_IAP && sec0 |-> req_denied_o) else $error("iap sector 0");
	chk_tool_all: assert property (
		take && mode_i == FSG_MODE_TOOL && lvd_enable_o && sec0 && req_i.op == FSG_OP_PROG
		|-> !req_denied_o) else $error("tool write refused");
	chk_user_deny: assert property (
		take && mode_i == FSG_MODE_USER |-> req_denied_o) else $error("user write taken");
	chk_icp_entry: assert property (
		take && mode_i == FSG_MODE_ICP && !icc_mode_i |-> req_denied_o) else $error("icp entry");
	chk_cmd_follow: assert property (
		take && !req_denied_o |=> cmd_valid_o && cmd_o.addr == $past(req_i.addr))
		else $error("command missing");
	chk_read_block: assert property (
		rd_ext_i && !lvd_enable_o |-> !rd_allow_o) else $error("protected read");
	chk_pins_taken: assert property (
		tool_attached_i |-> !app_pins_avail_o) else $error("pins still with application");
	chk_unprot_wipe: assert property (
		clk_en_i && opt_wr_i && !opt_prot_i && !lvd_enable_o && mode_i == FSG_MODE_TOOL &&
		flash_size_i == SIZE_BIG
		|=> cmd_valid_o && cmd_o.op == FSG_OP_BULK_ERASE && cmd_o.sec_mask == 3'h7)
		else $error("no wipe on unprotect");
endmodule : fsg_guard_chk

bind fsg_guard fsg_guard_chk u_chk (.*);

// ==== fsg_tool_model.sv ====
// Programming tool model on the in-circuit serial link.
// Assumes run_i frames the session; clock stands low outside it.
`timescale 1ns/1ps
module fsg_tool_model (
	// Session control
	input wire logic run_i,
	// Link pins
	output logic clk_o,
	output logic data_o
);
	initial begin
		{clk_o, data_o} = 2'h0;
	end
	// Data changes every half cycle so a stale value is never mistaken for a fresh one
	always begin
		#80;
		clk_o = run_i ? !clk_o : 1'b0;
		data_o = !data_o;
	end
endmodule : fsg_tool_model

// ==== test_flash_sector_write_guard.sv ====
// Self-checking bench for the sector write guard.
// Assumes the flash macro answers each command one cycle later.
`timescale 1ns/1ps
module test_flash_sector_write_guard
	import fsg_pkg::*;
;
	logic sys_clk_i, reset_i, clk_en_i, icc_mode_i, tool_attached_i, opt_wr_i, opt_prot_i;
	logic readout_protect_option_bit_i, req_valid_i, cmd_done_i, rd_ext_i, run;
	logic link_data_o_i, link_data_oe_i, app_data_o_i, app_data_oe_i, tool_clk, tool_d;
	logic [1:0] mode_i, flash_size_i;
	fsg_req_s req_i;
	fsg_cmd_s cmd_o;
	logic req_ready_o, req_denied_o, cmd_valid_o, rd_allow_o, lvd_enable_o, link_clk_rise_o;
	logic incircuit_serial_data_o, incircuit_serial_data_oe_o, link_data_o;
	logic app_pins_avail_o, app_clk_o, app_data_o;
	int err_count, compares;
	wire incircuit_serial_clock_i = tool_clk;
	// Tool drives the shared data line whenever the device lets go
	wire incircuit_serial_data_i = incircuit_serial_data_oe_o ? incircuit_serial_data_o : tool_d;
	fsg_guard u_fsg_guard (.*);
	fsg_tool_model u_fsg_tool_model (.run_i(run), .clk_o(tool_clk), .data_o(tool_d));
	always #2.5 sys_clk_i = !sys_clk_i;
	task results;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	task chk(input string n, input logic e, input logic s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %b seen %b", n, e, s);
		end
	endtask : chk
	task done;
		@(posedge sys_clk_i) cmd_done_i <= 1'b1;
		@(posedge sys_clk_i) cmd_done_i <= 1'b0;
	endtask : done
	task wait_cmd;
		for (int i = 0; i < 20; i++) begin
			#1;
			if (cmd_valid_o === 1'b1) break;
			@(posedge sys_clk_i);
		end
		chk("cmd_valid", 1'b1, cmd_valid_o);
		if (cmd_valid_o !== 1'b1) results();
	endtask : wait_cmd
	task req(input fsg_op_e op, input logic [15:0] a, input logic ok);
		@(posedge sys_clk_i) req_valid_i <= 1'b1;
		req_i <= '{op, a, 8'h5A};
		#1 chk("denied", !ok, req_denied_o);
		@(posedge sys_clk_i) req_valid_i <= 1'b0;
		#1 chk("cmd_valid", ok, cmd_valid_o);
		if (ok) begin
			chk("cmd_addr", 1'b1, cmd_o.addr === a);
			chk("cmd_data", 1'b1, cmd_o.data === 8'h5A);
			done();
		end
		@(posedge sys_clk_i);
	endtask : req
	task t_modes;
		mode_i <= FSG_MODE_TOOL;
		req(FSG_OP_PROG, 16'hFFFF, 1'b1);
		req(FSG_OP_BULK_ERASE, 16'h0000, 1'b1);
		req(FSG_OP_SEC_ERASE, 16'hE000, 1'b1);
		mode_i <= FSG_MODE_IAP;
		req(FSG_OP_PROG, 16'hF000, 1'b0);
		req(FSG_OP_SEC_ERASE, 16'hEFFF, 1'b1);
		mode_i <= FSG_MODE_USER;
		req(FSG_OP_PROG, 16'hE000, 1'b0);
		mode_i <= FSG_MODE_ICP;
		req(FSG_OP_PROG, 16'hE000, 1'b0);
		icc_mode_i <= 1'b1;
		req(FSG_OP_PROG, 16'hF000, 1'b1);
		req(FSG_OP_NONE, 16'hF000, 1'b0);
	endtask : t_modes
	task t_size;
		mode_i <= FSG_MODE_TOOL;
		flash_size_i <= SIZE_4K;
		req(FSG_OP_PROG, 16'hEFFF, 1'b0);
		flash_size_i <= SIZE_8K;
		req(FSG_OP_PROG, 16'hDFFF, 1'b0);
		req(FSG_OP_PROG, 16'hE000, 1'b1);
		flash_size_i <= SIZE_BIG;
		req(FSG_OP_PROG, 16'hDFFF, 1'b1);
	endtask : t_size
	task t_prot;
		{readout_protect_option_bit_i, rd_ext_i} <= 2'h3;
		repeat (2) @(posedge sys_clk_i);
		#1 chk("lvd", 1'b0, lvd_enable_o);
		chk("rd_allow", 1'b0, rd_allow_o);
		req(FSG_OP_PROG, 16'hE000, 1'b0);
		{opt_wr_i, opt_prot_i, readout_protect_option_bit_i} <= 3'h4;
		@(posedge sys_clk_i) opt_wr_i <= 1'b0;
		wait_cmd();
		chk("wipe", 1'b1, cmd_o.op === FSG_OP_BULK_ERASE && cmd_o.sec_mask === 3'h7);
		done();
		wait_cmd();
		chk("opt_write", 1'b1, cmd_o.op === FSG_OP_PROG && cmd_o.option === 1'b1);
		done();
		repeat (2) @(posedge sys_clk_i);
		#1 chk("lvd", 1'b1, lvd_enable_o);
		chk("rd_allow", 1'b1, rd_allow_o);
		@(posedge sys_clk_i);
	endtask : t_prot
	task t_pins;
		chk("avail", 1'b1, app_pins_avail_o);
		chk("app_data", 1'b1, incircuit_serial_data_o);
		{tool_attached_i, link_data_oe_i, run} <= 3'h7;
		for (int i = 0; i < 200 && link_clk_rise_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
		chk("clk_rise", 1'b1, link_clk_rise_o);
		chk("avail", 1'b0, app_pins_avail_o);
		chk("app_clk", 1'b0, app_clk_o);
		chk("app_data_in", 1'b0, app_data_o);
		chk("oe", 1'b1, incircuit_serial_data_oe_o);
		chk("link_data", 1'b0, link_data_o);
		@(posedge sys_clk_i) link_data_oe_i <= 1'b0;
		#1 chk("oe", 1'b0, incircuit_serial_data_oe_o);
	endtask : t_pins
	initial begin
		{sys_clk_i, icc_mode_i, tool_attached_i, opt_wr_i, opt_prot_i, req_valid_i} = '0;
		{cmd_done_i, rd_ext_i, run, link_data_o_i, link_data_oe_i, readout_protect_option_bit_i} = '0;
		{reset_i, clk_en_i, app_data_o_i, app_data_oe_i} = 4'hF;
		{mode_i, flash_size_i, req_i, err_count, compares} = '0;
		flash_size_i = SIZE_BIG;
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		t_modes();
		t_size();
		t_prot();
		t_pins();
		results();
	end
endmodule : test_flash_sector_write_guard
